// ---- hdl/cmpc_top.sv ----
// Purpose: register bank and digital control around two comparators
// Assumes: one peripheral clock, system reset only, word accesses
// Notes: raw comparator decisions are synchronised before any use
`timescale 1ns/1ns
module cmpc_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [cmpc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic [1:0] rawCmp,
    input wire logic [1:0] remapCode,
    output logic [1:0] cmpEnable,
    output logic [1:0] hyst1,
    output logic [1:0] hyst2,
    output logic speed1,
    output logic speed2,
    output logic [2:0] negSel1,
    output logic [2:0] negSel2,
    output logic [1:0] posSel1,
    output logic [1:0] posSel2,
    output logic windowMode,
    output logic externalInterruptLine19,
    output logic externalInterruptLine20,
    output logic [5:0] pinOut,
    output logic [5:0] pinOe,
    output logic tmr1Brk,
    output logic tmr1Cap1,
    output logic tmr1Clr,
    output logic tmr2Cap4,
    output logic tmr2Clr,
    output logic tmr3Cap1,
    output logic tmr3Clr
);
    import cmpc_pkg::*;

    logic [31:0] ctl1;
    logic [31:0] ctl2;
    logic lock1;
    logic lock2;
    logic [1:0] syncCmp;
    logic value1;
    logic value2;
    logic wrCs1;
    logic wrCs2;
    logic [31:0] openMask;
    logic [31:0] cs1View;
    logic [31:0] cs2View;
    logic [7:1] timerIn;

    function automatic logic [31:0] mergeBits(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    assign wrCs1 = regWrite && (regAddr == OFF_CS1);
    assign wrCs2 = regWrite && (regAddr == OFF_CS2);
    // halves still open for writing
    assign openMask = (lock2 ? 32'h00000000 : MASK_HI) | (lock1 ? 32'h00000000 : MASK_LO);

    // control words; a locked half simply keeps its value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl1 <= CTL1_RST;
        end else if (wrCs1) begin
            ctl1 <= mergeBits(ctl1, regWdata, CS1_WR & openMask);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl2 <= CTL2_RST;
        end else if (wrCs2) begin
            ctl2 <= mergeBits(ctl2, regWdata, CS2_WR & openMask);
        end
    end

    // lock bits only ever set; reset is the only way out
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock1 <= 1'b0;
            lock2 <= 1'b0;
        end else if (wrCs1) begin
            lock1 <= lock1 | regWdata[B_LOCK1];
            lock2 <= lock2 | regWdata[B_LOCK2];
        end
    end

    cmpc_sync uSync (
        .clk(clk),
        .resetn(resetn),
        .rawIn(rawCmp),
        .syncOut(syncCmp)
    );

    // disabled comparator reports zero
    assign value1 = ctl1[B_EN1] & (syncCmp[0] ^ ctl1[B_POL1]);
    assign value2 = ctl1[B_EN2] & (syncCmp[1] ^ ctl1[B_POL2]);

    // no clock gating here, so events keep flowing while the core sleeps
    assign externalInterruptLine19 = value1;
    assign externalInterruptLine20 = value2;

    // analog controls straight from the control flops
    assign cmpEnable = {ctl1[B_EN2], ctl1[B_EN1]};
    assign hyst1 = ctl1[B_HYST1 +: 2];
    assign hyst2 = ctl1[B_HYST2 +: 2];
    assign speed1 = ctl1[B_SPD1];
    assign speed2 = ctl1[B_SPD2];
    assign negSel1 = ctl1[B_NEG1 +: 3];
    assign negSel2 = ctl1[B_NEG2 +: 3];
    assign windowMode = ctl1[B_WIN];
    assign posSel1 = ctl2[B_POS1 +: 2];
    // window mode ties the second positive input to the first
    assign posSel2 = ctl1[B_WIN] ? ctl2[B_POS1 +: 2] : ctl2[B_POS2 +: 2];

    cmpc_route uRoute (
        .clk(clk),
        .resetn(resetn),
        .value1(value1),
        .value2(value2),
        .tag1(cmpc_target_t'(ctl1[B_TAG1 +: 3])),
        .tag2(cmpc_target_t'(ctl1[B_TAG2 +: 3])),
        .remapCode(remapCode),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .timerIn(timerIn)
    );

    assign tmr1Brk = timerIn[TGT_T1_BRK];
    assign tmr1Cap1 = timerIn[TGT_T1_CAP1];
    assign tmr1Clr = timerIn[TGT_T1_CLR];
    assign tmr2Cap4 = timerIn[TGT_T2_CAP4];
    assign tmr2Clr = timerIn[TGT_T2_CLR];
    assign tmr3Cap1 = timerIn[TGT_T3_CAP1];
    assign tmr3Clr = timerIn[TGT_T3_CLR];

    // read views: live lock and value bits merged with stored control
    always_comb begin
        cs1View = ctl1 | CS1_ONES;
        cs1View[B_LOCK1] = lock1;
        cs1View[B_LOCK2] = lock2;
        cs1View[B_VAL1] = value1;
        cs1View[B_VAL2] = value2;
        cs2View = ctl2;
    end

    // read data registered; unmapped addresses read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            case (regAddr)
                OFF_CS1: regRdata <= cs1View;
                OFF_CS2: regRdata <= cs2View;
                default: regRdata <= 32'h00000000;
            endcase
        end
    end

    sequence seqLockedWrite1;
        lock1 && wrCs1;
    endsequence

    sequence seqLockedWrite2;
        lock2 && (wrCs1 || wrCs2);
    endsequence

    sequence seqSteadyHigh1;
        (ctl1[B_EN1] && !ctl1[B_POL1] && rawCmp[0])[*3];
    endsequence

    sequence seqSteadyHigh2;
        (ctl1[B_EN2] && !ctl1[B_POL2] && rawCmp[1])[*3];
    endsequence

    AST_LOCK1_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
        seqLockedWrite1 |=> $stable(ctl1[15:0]) && $stable(ctl2[15:0]))
        else $error("locked low half changed on write");

    AST_LOCK2_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
        seqLockedWrite2 |=> $stable(ctl1[31:16]) && $stable(ctl2[31:16]))
        else $error("locked high half changed on write");

    AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (!resetn)
        (lock1 || lock2) |=> (lock1 >= $past(lock1)) && (lock2 >= $past(lock2)))
        else $error("lock bit cleared without reset");

    AST_OPEN_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        (wrCs1 && !lock1 && !lock2) |=> ctl1 == ($past(regWdata) & CS1_WR))
        else $error("unlocked write not stored");

    AST_LINE19_HIGH: assert property (@(posedge clk) disable iff (!resetn)
        seqSteadyHigh1 |-> externalInterruptLine19 && cs1View[B_VAL1])
        else $error("line 19 not raised after steady high");

    AST_LINE20_HIGH: assert property (@(posedge clk) disable iff (!resetn)
        seqSteadyHigh2 |-> externalInterruptLine20 && cs1View[B_VAL2])
        else $error("line 20 not raised after steady high");

    AST_POLARITY: assert property (@(posedge clk) disable iff (!resetn)
        (ctl1[B_EN1] && ctl1[B_POL1] && rawCmp[0])[*3] |-> !externalInterruptLine19)
        else $error("polarity did not invert output");

    AST_WINDOW_POS: assert property (@(posedge clk) disable iff (!resetn)
        windowMode |-> posSel2 == ctl2[B_POS1 +: 2])
        else $error("window mode positive inputs differ");

    AST_READ_LOCK: assert property (@(posedge clk) disable iff (!resetn)
        (regRead && regAddr == OFF_CS1) |=> regRdata[B_LOCK1] == $past(lock1))
        else $error("read lock bit wrong");

    AST_BRK_ROUTE: assert property (@(posedge clk) disable iff (!resetn)
        (value1 && ctl1[B_TAG1 +: 3] == TGT_T1_BRK) |=> tmr1Brk)
        else $error("break input not driven");

    // the synchroniser must have seen two edges out of reset
    sequence seqSyncReady1;
        ctl1[B_EN1] && $past(resetn, 2);
    endsequence

    sequence seqSyncReady2;
        ctl1[B_EN2] && $past(resetn, 2);
    endsequence

    AST_VALUE1_SYNC: assert property (@(posedge clk) disable iff (!resetn)
        seqSyncReady1 |-> value1 == ($past(rawCmp[0], 2) ^ ctl1[B_POL1]))
        else $error("first value does not follow synchronised input");

    AST_VALUE2_SYNC: assert property (@(posedge clk) disable iff (!resetn)
        seqSyncReady2 |-> value2 == ($past(rawCmp[1], 2) ^ ctl1[B_POL2]))
        else $error("second value does not follow synchronised input");

    AST_REMAP_A: assert property (@(posedge clk) disable iff (!resetn)
        (remapCode == REMAP_A) |=> pinOe == 6'h03)
        else $error("remap code zero drives wrong pins");

    AST_REMAP_B: assert property (@(posedge clk) disable iff (!resetn)
        (remapCode == REMAP_B) |=> pinOe == 6'h0c)
        else $error("remap code one drives wrong pins");

    AST_REMAP_C: assert property (@(posedge clk) disable iff (!resetn)
        (remapCode == REMAP_C) |=> pinOe == 6'h30)
        else $error("remap code two drives wrong pins");

    AST_PIN_FIRST: assert property (@(posedge clk) disable iff (!resetn)
        value1 |=> pinOut[0] && pinOut[2] && pinOut[4])
        else $error("first output missing on its pins");

    AST_PIN_SECOND: assert property (@(posedge clk) disable iff (!resetn)
        value2 |=> pinOut[1] && pinOut[3] && pinOut[5])
        else $error("second output missing on its pins");

    AST_CAP1_ROUTE: assert property (@(posedge clk) disable iff (!resetn)
        (value1 && ctl1[B_TAG1 +: 3] == TGT_T1_CAP1) |=> tmr1Cap1)
        else $error("capture input not driven");

    AST_T3CLR_ROUTE: assert property (@(posedge clk) disable iff (!resetn)
        (value1 && ctl1[B_TAG1 +: 3] == TGT_T3_CLR) |=> tmr3Clr)
        else $error("compare clear input not driven");

    AST_NO_ROUTE: assert property (@(posedge clk) disable iff (!resetn)
        (ctl1[B_TAG1 +: 3] == TGT_NONE && ctl1[B_TAG2 +: 3] == TGT_NONE) |=> timerIn == 7'h00)
        else $error("timer input driven with no target");

    AST_OFF1_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        !ctl1[B_EN1] |-> !externalInterruptLine19)
        else $error("disabled first comparator raised line 19");

    AST_OFF2_ZERO: assert property (@(posedge clk) disable iff (!resetn)
        !ctl1[B_EN2] |-> !externalInterruptLine20)
        else $error("disabled second comparator raised line 20");

    AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (!resetn)
        (regWrite && !wrCs1 && !wrCs2) |=> $stable(ctl1) && $stable(ctl2) && $stable({lock2, lock1}))
        else $error("unmapped write changed a register");

    AST_LOCK1_CS2: assert property (@(posedge clk) disable iff (!resetn)
        (lock1 && wrCs2) |=> $stable(ctl2[15:0]))
        else $error("locked low half of second register changed");

    AST_READ_VALUE: assert property (@(posedge clk) disable iff (!resetn)
        (regRead && regAddr == OFF_CS1) |=>
            (regRdata[B_VAL1] == $past(value1)) && (regRdata[B_VAL2] == $past(value2)))
        else $error("read value bits wrong");

    AST_READ_CS2: assert property (@(posedge clk) disable iff (!resetn)
        (regRead && regAddr == OFF_CS2) |=> regRdata == $past(ctl2))
        else $error("second register read wrong");

    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !regRead |=> $stable(regRdata))
        else $error("read data changed without a read");
endmodule

// ---- hdl/cmpc_pkg.sv ----
// Purpose: shared constants for the comparator control logic
// Assumes: word accesses only, byte addresses on the register port
// Notes: bit positions are plain ints, masks and reset values are 32-bit
package cmpc_pkg;
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] OFF_CS1 = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_CS2 = 3'h4;

    localparam logic [31:0] RST_CS1 = 32'h00000080;
    localparam logic [31:0] RST_CS2 = 32'h00010001;
    // reserved bits of the first register that read as one
    localparam logic [31:0] CS1_ONES = 32'h00000080;
    // plain read/write bits, lock and value bits excluded
    localparam logic [31:0] CS1_WR = 32'h3ff53f75;
    localparam logic [31:0] CS2_WR = 32'h00030003;
    localparam logic [31:0] CTL1_RST = RST_CS1 & CS1_WR;
    localparam logic [31:0] CTL2_RST = RST_CS2 & CS2_WR;
    localparam logic [31:0] MASK_HI = 32'hffff0000;
    localparam logic [31:0] MASK_LO = 32'h0000ffff;

    // first control/status register, second comparator half
    localparam int B_LOCK2 = 31;
    localparam int B_VAL2 = 30;
    localparam int B_HYST2 = 28;
    localparam int B_POL2 = 27;
    localparam int B_TAG2 = 24;
    localparam int B_WIN = 23;
    localparam int B_NEG2 = 20;
    localparam int B_SPD2 = 18;
    localparam int B_EN2 = 16;
    // first control/status register, first comparator half
    localparam int B_LOCK1 = 15;
    localparam int B_VAL1 = 14;
    localparam int B_HYST1 = 12;
    localparam int B_POL1 = 11;
    localparam int B_TAG1 = 8;
    localparam int B_NEG1 = 4;
    localparam int B_SPD1 = 2;
    localparam int B_EN1 = 0;
    // second control/status register
    localparam int B_POS2 = 16;
    localparam int B_POS1 = 0;

    localparam logic [1:0] REMAP_A = 2'h0;
    localparam logic [1:0] REMAP_B = 2'h1;
    localparam logic [1:0] REMAP_C = 2'h2;

    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_T1_BRK = 3'b001,
        TGT_T1_CAP1 = 3'b010,
        TGT_T1_CLR = 3'b011,
        TGT_T2_CAP4 = 3'b100,
        TGT_T2_CLR = 3'b101,
        TGT_T3_CAP1 = 3'b110,
        TGT_T3_CLR = 3'b111
    } cmpc_target_t;
endpackage

// ---- hdl/cmpc_sync.sv ----
// Purpose: two-stage synchroniser for the raw comparator outputs
// Assumes: inputs are asynchronous analog decisions
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module cmpc_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] rawIn,
    output logic [1:0] syncOut
);
    logic [1:0] stageA;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stageA <= 2'h0;
            syncOut <= 2'h0;
        end else begin
            stageA <= rawIn;
            syncOut <= stageA;
        end
    end
endmodule

// ---- hdl/cmpc_route.sv ----
// Purpose: routes comparator results to port pins and timer inputs
// Assumes: remap code comes from the pin remap register outside
// Notes: all outputs are registered, one cycle behind the values or the remap code
`timescale 1ns/1ns
module cmpc_route (
    input wire logic clk,
    input wire logic resetn,
    input wire logic value1,
    input wire logic value2,
    input wire cmpc_pkg::cmpc_target_t tag1,
    input wire cmpc_pkg::cmpc_target_t tag2,
    input wire logic [1:0] remapCode,
    output logic [5:0] pinOut,
    output logic [5:0] pinOe,
    output logic [7:1] timerIn
);
    import cmpc_pkg::*;

    function automatic logic [7:0] decodeTarget(input cmpc_target_t t, input logic v);
        logic [7:0] r;
        r = 8'h00;
        r[t] = v;
        return r;
    endfunction

    logic [7:0] hit1;
    logic [7:0] hit2;
    assign hit1 = decodeTarget(tag1, value1);
    assign hit2 = decodeTarget(tag2, value2);

    // pin order: pa0 pa2 pa6 pa7 pa11 pa12
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinOut <= 6'h00;
            pinOe <= 6'h00;
        end else begin
            pinOut <= {value2, value1, value2, value1, value2, value1};
            case (remapCode)
                REMAP_A: pinOe <= 6'h03;
                REMAP_B: pinOe <= 6'h0c;
                REMAP_C: pinOe <= 6'h30;
                default: pinOe <= 6'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timerIn <= 7'h00;
        end else begin
            timerIn <= hit1[7:1] | hit2[7:1];
        end
    end
endmodule

// ---- verif/cmpc_analog_model.sv ----
// Purpose: behavioural analog core pair feeding raw decisions to the block
// Assumes: sensed pins are already in analog mode
// Notes: a disabled core gives a decision that changes every cycle
`timescale 1ns/1ns
module cmpc_analog_model (
    input wire logic clk,
    input wire logic [1:0] cmpEnable,
    output logic [1:0] rawCmp
);
    logic [1:0] level = 2'h0;
    logic junk = 1'b0;

    // decisions land a few ns after the edge, unrelated to sampling
    always @(posedge clk) begin
        junk <= #3 ~junk;
    end

    assign rawCmp = {cmpEnable[1] ? level[1] : junk, cmpEnable[0] ? level[0] : junk};

    // bench sets the analog outcome; sensed pins count as analog
    task automatic setLevel(input logic [1:0] l);
        level = l;
    endtask
endmodule

// ---- verif/tb_comparator_control_logic.sv ----
// Purpose: self-checking bench for the comparator control logic
// Assumes: word accesses, one cycle read latency
// Notes: expectations follow the register layout and routing codes
`timescale 1ns/1ns
module tb_comparator_control_logic;
    import cmpc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [ADDR_W-1:0] regAddr = 3'h0;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic [1:0] rawCmp, cmpEnable, hyst1, hyst2, posSel1, posSel2;
    logic [1:0] remapCode = 2'h0;
    logic speed1, speed2, windowMode, externalInterruptLine19, externalInterruptLine20;
    logic [2:0] negSel1, negSel2;
    logic [5:0] pinOut, pinOe;
    logic [7:1] tmr;
    logic [1:0] irqLines;
    int n_errors = 0;
    int checks = 0;

    always #5 clk = ~clk;
    assign irqLines = {externalInterruptLine20, externalInterruptLine19};

    cmpc_analog_model analog (.clk(clk), .cmpEnable(cmpEnable), .rawCmp(rawCmp));

    cmpc_top dut (.clk(clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .rawCmp(rawCmp),
        .remapCode(remapCode), .cmpEnable(cmpEnable), .hyst1(hyst1), .hyst2(hyst2),
        .speed1(speed1), .speed2(speed2), .negSel1(negSel1), .negSel2(negSel2),
        .posSel1(posSel1), .posSel2(posSel2), .windowMode(windowMode),
        .externalInterruptLine19(externalInterruptLine19),
        .externalInterruptLine20(externalInterruptLine20), .pinOut(pinOut), .pinOe(pinOe),
        .tmr1Brk(tmr[1]), .tmr1Cap1(tmr[2]), .tmr1Clr(tmr[3]), .tmr2Cap4(tmr[4]),
        .tmr2Clr(tmr[5]), .tmr3Cap1(tmr[6]), .tmr3Clr(tmr[7]));

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic doReset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
    endtask

    // whole-word write, one strobe cycle
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        check(regRdata, exp);
    endtask

    task automatic tReset();
        rd(OFF_CS1, 32'h00000080);
        rd(OFF_CS2, 32'h00010001);
        wr(3'h2, 32'hffffffff);
        rd(3'h2, 32'h0);
        rd(OFF_CS1, 32'h00000080);
        cyc(4);
        check({30'h0, irqLines}, 32'h0);
    endtask

    task automatic tFields();
        wr(OFF_CS1, 32'h3ff43f74);
        rd(OFF_CS1, 32'h3ff43ff4);
        check({25'h0, hyst2, hyst1, speed2, speed1, windowMode}, 32'h7f);
        check({26'h0, negSel2, negSel1}, 32'h3f);
        wr(OFF_CS2, 32'h00020003);
        rd(OFF_CS2, 32'h00020003);
        check({28'h0, posSel2, posSel1}, 32'hf);
        wr(OFF_CS1, 32'h0);
        check({28'h0, posSel2, posSel1}, 32'hb);
    endtask

    task automatic tValue();
        wr(OFF_CS1, 32'h00010001);
        check({30'h0, cmpEnable}, 32'h3);
        analog.setLevel(2'b01);
        cyc(4);
        check({30'h0, irqLines}, 32'h1);
        rd(OFF_CS1, 32'h00014081);
        wr(OFF_CS1, 32'h00010881);
        rd(OFF_CS1, 32'h00010881);
        analog.setLevel(2'b10);
        wr(OFF_CS1, 32'h00010001);
        cyc(4);
        check({30'h0, irqLines}, 32'h2);
        rd(OFF_CS1, 32'h40010081);
    endtask

    task automatic tRoute();
        analog.setLevel(2'b01);
        for (int t = 0; t < 8; t++) begin
            wr(OFF_CS1, 32'h00010001 | {21'h0, 3'(t), 8'h0});
            cyc(4);
            check({25'h0, tmr}, (t == 0) ? 32'h0 : 32'h1 << (t - 1));
        end
    endtask

    task automatic tRemap();
        logic [5:0] m;
        // only the first comparator high, so each pin shows whose output it carries
        analog.setLevel(2'b01);
        wr(OFF_CS1, 32'h00010001);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            remapCode <= 2'(c);
            cyc(4);
            m = (c == 3) ? 6'h0 : 6'h3 << (2 * c);
            check({20'h0, pinOe, pinOut}, {20'h0, m, 6'h15});
        end
    endtask

    task automatic tLock();
        doReset();
        wr(OFF_CS1, 32'h00008004);
        rd(OFF_CS1, 32'h00008084);
        wr(OFF_CS1, 32'h00040000);
        rd(OFF_CS1, 32'h00048084);
        wr(OFF_CS2, 32'h00030002);
        rd(OFF_CS2, 32'h00030001);
        doReset();
        rd(OFF_CS1, 32'h00000080);
        wr(OFF_CS1, 32'h80040000);
        rd(OFF_CS1, 32'h80040080);
        wr(OFF_CS1, 32'h00000004);
        rd(OFF_CS1, 32'h80040084);
        wr(OFF_CS2, 32'h00020002);
        rd(OFF_CS2, 32'h00010002);
    endtask

    // guard against a hang anywhere in the sequence
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial begin
        doReset();
        tReset();
        tFields();
        tValue();
        tRoute();
        tRemap();
        tLock();
        print_verdict();
    end
endmodule
